// File: async_serial_baud_and_register_map_tb.sv
// Self-checking bench for the serial port front end over APB.
// Assumes the serial peer model and an APB slave that may insert wait states.
`timescale 1ns/10ps
module async_serial_baud_and_register_map_tb;
   import serial_port_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic clk_en = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic rx_in;
   logic tx_out;
   logic tx_oe_n;
   logic tx_pin;
   int n_fail = 0;
   int checks_done = 0;
   logic [8:0] v;
   logic [31:0] r;
   int w;
   int p;
   int lows;
   logic [4:0] pw [4] = '{PULSE_3_16, PULSE_1_16, PULSE_1_32, PULSE_QUARTER};

   always #5 pclk = ~pclk;
   // Released pin floats to the pull-up level
   assign tx_pin = (tx_oe_n === 1'b0) ? tx_out : 1'b1;

   serial_port #(.DIV_WIDTH(13)) dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_in(rx_in), .tx_out(tx_out),
      .tx_oe_n(tx_oe_n));
   serial_peer_model peer_u (.clk(pclk), .tx_line(tx_pin), .rx_line(rx_in));

   // ==========================================
   // Bus and compare tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic apb(input logic [11:0] a, input logic wr_en, input logic [7:0] d,
                      output logic [31:0] rd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr_en;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      // Waits as long as the slave needs; only the watchdog ends a hang
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      chk(pslverr, 1'b0);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [2:0] i, input logic [7:0] d);
      logic [31:0] rd;
      apb({7'h0, i, 2'b00}, 1'b1, d, rd);
   endtask : wr

   task automatic rd_chk(input logic [2:0] i, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] rd;
      apb({7'h0, i, 2'b00}, 1'b0, 8'h00, rd);
      chk(rd & m, e);
   endtask : rd_chk

   task automatic final_report;
      $display("checks %0d fails %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : final_report

   // A full run is near 4.5k cycles; this 40k-cycle watchdog sits well above it and cuts a hang
   initial begin
      #400000;
      n_fail++;
      final_report();
   end

   // ==========================================
   // Test sequence
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      #1 chk(tx_oe_n, 1'b1);
      rd_chk(IDX_BAUD_LOW, 32'hffffffff, 32'h04);
      rd_chk(IDX_BAUD_HIGH, 32'hffffffff, 32'h00);
      wr(IDX_BAUD_HIGH, 8'h01);
      rd_chk(IDX_BAUD_HIGH, 32'hffffffff, 32'h00);
      wr(IDX_BAUD_LOW, 8'h00);
      rd_chk(IDX_BAUD_HIGH, 32'hffffffff, 32'h01);
      rd_chk(IDX_BAUD_LOW, 32'hffffffff, 32'h00);
      wr(IDX_BAUD_HIGH, 8'h20);
      wr(IDX_BAUD_LOW, 8'h02);
      // Reserved space and misaligned bytes must not alias real registers
      apb(12'h024, 1'b1, 8'hff, r);
      apb(12'h005, 1'b1, 8'h77, r);
      apb(12'h024, 1'b0, 8'h00, r);
      chk(r, 32'h0);
      apb(12'h006, 1'b0, 8'h00, r);
      chk(r, 32'h0);
      rd_chk(IDX_BAUD_LOW, 32'hffffffff, 32'h02);
      wr(IDX_LINE_STAT_TWO, 8'h80);
      rd_chk(IDX_BAUD_HIGH, 32'hffffffff, 32'h00);
      wr(IDX_BAUD_LOW, 8'h03);
      rd_chk(IDX_BAUD_LOW, 32'hffffffff, 32'h03);
      wr(IDX_LINE_CTRL_ONE, 8'hff);
      rd_chk(IDX_LINE_CTRL_ONE, 32'hffffffff, 32'h07);
      rd_chk(IDX_LINE_STAT_TWO, 32'h80, 32'h80);
      wr(IDX_LINE_STAT_TWO, 8'h00);
      rd_chk(IDX_BAUD_LOW, 32'hffffffff, 32'h02);
      rd_chk(IDX_LINE_CTRL_ONE, 32'hffffffff, 32'h00);
      // Standard frame: bit time is 16 x divisor cycles
      wr(IDX_LINE_CTRL_TWO, 8'h08);
      rd_chk(IDX_LINE_CTRL_TWO, 32'hff, 32'h08);
      repeat (2) @(posedge pclk);
      #1 chk(tx_oe_n, 1'b0);
      chk(tx_pin, 1'b1);
      fork
         peer_u.get(9, 32, v, w);
         wr(IDX_DATA_LOW, 8'ha5);
      join
      chk(w, 32);
      chk(v, 9'h1a5);
      wr(IDX_LINE_STAT_TWO, 8'h10);
      repeat (3) @(posedge pclk);
      #1 chk(tx_out, 1'b0);
      wr(IDX_LINE_STAT_TWO, 8'h00);
      // Infrared: divisor 5 acts as 2, so bit time is 64 cycles
      for (int c = 0; c < 4; c++) begin
         wr(IDX_BAUD_HIGH, 8'h80 | 8'(c << 5));
         wr(IDX_BAUD_LOW, 8'h05);
         repeat (4) @(posedge pclk);
         #1 chk(tx_pin, 1'b1);
         fork
            peer_u.pulse(w, p);
            wr(IDX_DATA_LOW, 8'hfe);
         join
         chk(w, 2 * int'(pw[c]));
         chk(p, 64);
         repeat (640) @(posedge pclk);
      end
      wr(IDX_BAUD_HIGH, 8'h00);
      wr(IDX_BAUD_LOW, 8'h02);
      // Receiver disabled: a frame must leave the full flag clear
      peer_u.send(9'h055, 8, 32);
      rd_chk(IDX_LINE_STAT_ONE, 32'h20, 32'h00);
      wr(IDX_LINE_CTRL_ONE, 8'h10);
      wr(IDX_LINE_CTRL_TWO, 8'h0c);
      repeat (100) @(posedge pclk);
      peer_u.send(9'h1c3, 9, 32);
      rd_chk(IDX_LINE_STAT_ONE, 32'h20, 32'h20);
      rd_chk(IDX_DATA_HIGH, 32'h80, 32'h80);
      rd_chk(IDX_DATA_LOW, 32'hff, 32'hc3);
      // Zero divisor halts the generator, so the line never leaves idle
      wr(IDX_BAUD_HIGH, 8'h00);
      wr(IDX_BAUD_LOW, 8'h00);
      wr(IDX_DATA_LOW, 8'h00);
      lows = 0;
      repeat (300) begin
         @(posedge pclk);
         if (tx_pin !== 1'b1) lows++;
      end
      chk(lows, 0);
      wr(IDX_LINE_CTRL_TWO, 8'h00);
      repeat (2) @(posedge pclk);
      #1 chk(tx_oe_n, 1'b1);
      final_report();
   end
endmodule : async_serial_baud_and_register_map_tb

// File: serial_peer_model.sv
// Behavioural far-end serial peer: drives the receive line, times the transmit line.
// Assumes both lines are sampled on the bus clock and the transmit pin has a pull-up.
`timescale 1ns/10ps
module serial_peer_model (
   // Clock
   input wire logic clk,
   // Serial lines
   input wire logic tx_line,
   output logic rx_line
);
   // Held high between frames so a disabled receiver never sees a floating pin
   initial rx_line = 1'b1;

   // ==========================================
   // Frame sender: start low, data LSB first, stop high
   task automatic send(input logic [8:0] v, input int nbits, input int bitc);
      @(posedge clk);
      rx_line <= 1'b0;
      repeat (bitc) @(posedge clk);
      for (int i = 0; i < nbits; i++) begin
         rx_line <= v[i];
         repeat (bitc) @(posedge clk);
      end
      rx_line <= 1'b1;
      repeat (2 * bitc) @(posedge clk);
   endtask : send

   // ==========================================
   // Line timing: cycles high before a fall, then cycles low
   task automatic wait_fall(output int h, output int w);
      h = 0;
      w = 0;
      while (tx_line !== 1'b0 && h < 20000) begin
         @(posedge clk);
         h++;
      end
      while (tx_line === 1'b0 && w < 20000) begin
         @(posedge clk);
         w++;
      end
   endtask : wait_fall

   // Samples each bit in its middle, counted from the start-bit fall
   task automatic get(input int nbits, input int bitc, output logic [8:0] v, output int w);
      int h;
      v = '0;
      wait_fall(h, w);
      repeat (bitc + bitc / 2 - w) @(posedge clk);
      for (int i = 0; i < nbits; i++) begin
         v[i] = tx_line;
         repeat (bitc) @(posedge clk);
      end
   endtask : get

   // Width of the first low pulse and the fall-to-fall spacing
   task automatic pulse(output int w, output int p);
      int h;
      int w2;
      wait_fall(h, w);
      wait_fall(h, w2);
      p = w + h;
   endtask : pulse
endmodule : serial_peer_model

// File: serial_port.sv
// Serial port front end: APB registers, baud generator, transmit/receive shifters.
// Assumes pins synchronous to pclk and a pad that resolves tx from its enable.
`timescale 1ns/10ps
module serial_port
   import serial_port_pkg::*;
#(
   parameter int DIV_WIDTH = 13
) (
   // Clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial pins
   input wire logic rx_in,
   output logic tx_out,
   output logic tx_oe_n
);
   // Elaboration guard: the register split only serves a 13-bit divisor
   if (DIV_WIDTH != 13) begin : g_bad_div_width
      $error("serial_port: divisor width must be 13");
   end

   // ==========================================
   // State
   typedef struct packed {
      logic [7:0] baud_high;
      logic [7:0] baud_high_hold;
      logic [7:0] baud_low;
      logic [7:0] ctrl_one;
      logic [7:0] ctrl_two;
      logic [7:0] stat_two;
      logic [7:0] alt_ctrl_one;
      logic [2:0] alt_ctrl_two;
      logic started;
      logic [12:0] baud_cnt;
      logic tick;
      // transmitter
      tx_state_t tx_state;
      logic [10:0] tx_shift;
      logic [3:0] tx_bits;
      logic [4:0] tx_sub;
      logic [8:0] tx_data;
      logic tx_full;
      logic tx_done;
      logic tx_line;
      logic tx_oe_n;
      logic tx_pin;
      // receiver
      rx_state_t rx_state;
      logic [8:0] rx_shift;
      logic [3:0] rx_bits;
      logic [4:0] rx_sub;
      logic [8:0] rx_data;
      logic rx_full;
      logic rx_overrun;
      logic rx_frame_err;
      logic rx_idle_flag;
      logic [4:0] idle_cnt;
      logic [31:0] prdata;
      logic pready;
   } state_t;

   state_t s_reg, s_next;

   function automatic logic [4:0] pulse_width(input logic [1:0] sel);
      case (sel)
         2'b11: pulse_width = PULSE_QUARTER;
         2'b10: pulse_width = PULSE_1_32;
         2'b01: pulse_width = PULSE_1_16;
         default: pulse_width = PULSE_3_16;
      endcase
   endfunction : pulse_width

   logic ir_on;
   logic [12:0] divisor;
   logic [12:0] eff_div;
   logic baud_run;
   logic alt_map;
   logic access;
   logic [2:0] idx;
   logic mapped;
   logic rx_level;
   logic nine;
   logic [7:0] rdata8;
   logic [7:0] status_one;
   logic rx_read;

   always_comb begin
      ir_on = s_reg.baud_high[BIT_INFRARED_ENABLE];
      divisor = {s_reg.baud_high[POS_DIV_HI:0], s_reg.baud_low};
      // Infrared halves bit 0 out and doubles the prescale: 32 x SBR[12:1]
      eff_div = ir_on ? {1'b0, divisor[12:1]} : divisor;
      baud_run = s_reg.started && (eff_div != 13'h0000);
      alt_map = s_reg.stat_two[BIT_ALT_MAP];
      access = psel && penable;
      idx = paddr[4:2];
      mapped = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'b00);
      nine = s_reg.ctrl_one[BIT_CHAR_LENGTH];
      rx_read = access && s_reg.pready && !pwrite && mapped && (idx == IDX_DATA_LOW);
      // Disabled receiver sees a steady idle level
      rx_level = s_reg.ctrl_two[BIT_RX_ENABLE] ?
                 (rx_in ^ s_reg.stat_two[BIT_RX_POL]) : 1'b1;
      status_one = {!s_reg.tx_full, s_reg.tx_done, s_reg.rx_full, s_reg.rx_idle_flag,
                    s_reg.rx_overrun, 1'b0, s_reg.rx_frame_err, 1'b0};
      rdata8 = 8'h00;
      case (idx)
         IDX_BAUD_HIGH: rdata8 = alt_map ? 8'h00 : s_reg.baud_high;
         IDX_BAUD_LOW: rdata8 = alt_map ? s_reg.alt_ctrl_one : s_reg.baud_low;
         IDX_LINE_CTRL_ONE: rdata8 = alt_map ? {5'h00, s_reg.alt_ctrl_two} : s_reg.ctrl_one;
         IDX_LINE_CTRL_TWO: rdata8 = s_reg.ctrl_two;
         IDX_LINE_STAT_ONE: rdata8 = status_one;
         IDX_LINE_STAT_TWO: rdata8 = s_reg.stat_two;
         IDX_DATA_HIGH: rdata8 = {s_reg.rx_data[8], s_reg.tx_data[8], 6'h00};
         IDX_DATA_LOW: rdata8 = s_reg.rx_data[7:0];
         default: rdata8 = 8'h00;
      endcase
      if (!mapped) begin
         rdata8 = 8'h00;
      end
   end

   // ==========================================
   // Next state
   always_comb begin
      s_next = s_reg;
      s_next.pready = 1'b0;
      s_next.tick = 1'b0;
      // Ready is registered: the access cycle right after every setup answers
      if (psel && !penable) begin
         s_next.pready = 1'b1;
         s_next.prdata = {24'h000000, rdata8};
      end
      // Baud generator: one tick per 1/16 bit (or 1/32 in infrared)
      if (baud_run) begin
         if (s_reg.baud_cnt >= eff_div - 13'h0001) begin
            s_next.baud_cnt = 13'h0000;
            s_next.tick = 1'b1;
         end else begin
            s_next.baud_cnt = s_reg.baud_cnt + 13'h0001;
         end
      end else begin
         s_next.baud_cnt = 13'h0000;
      end
      // Transmitter
      if (!s_reg.ctrl_two[BIT_TX_ENABLE]) begin
         s_next.tx_oe_n = 1'b1;
         s_next.tx_state = TX_IDLE;
         s_next.tx_line = 1'b1;
      end else begin
         s_next.tx_oe_n = 1'b0;
         case (s_reg.tx_state)
            TX_IDLE: begin
               s_next.tx_line = 1'b1;
               if (s_reg.tx_full && s_reg.tick) begin
                  s_next.tx_shift = nine ? {1'b1, s_reg.tx_data, 1'b0} :
                                    {2'b11, s_reg.tx_data[7:0], 1'b0};
                  s_next.tx_bits = nine ? 4'hb : 4'ha;
                  s_next.tx_sub = 5'h00;
                  s_next.tx_full = 1'b0;
                  s_next.tx_done = 1'b0;
                  s_next.tx_state = TX_SHIFT;
               end
            end
            TX_SHIFT: begin
               if (ir_on) begin
                  // Zero bit: narrow low pulse at the start of the bit cell
                  s_next.tx_line = !(!s_reg.tx_shift[0] &&
                                     (s_reg.tx_sub < pulse_width(s_reg.baud_high[6:5])));
               end else begin
                  s_next.tx_line = s_reg.tx_shift[0];
               end
               if (s_reg.tick) begin
                  if (s_reg.tx_sub == (ir_on ? 5'h1f : 5'h0f)) begin
                     s_next.tx_sub = 5'h00;
                     s_next.tx_shift = {1'b1, s_reg.tx_shift[10:1]};
                     s_next.tx_bits = s_reg.tx_bits - 4'h1;
                     if (s_reg.tx_bits == 4'h1) begin
                        s_next.tx_state = TX_IDLE;
                        s_next.tx_done = 1'b1;
                     end
                  end else begin
                     s_next.tx_sub = s_reg.tx_sub + 5'h01;
                  end
               end
            end
            default: s_next.tx_state = TX_IDLE;
         endcase
      end
      // Reading the low data byte releases the receive buffer; a byte that
      // completes in the same cycle still sets the flag, so none is lost
      if (rx_read) begin
         s_next.rx_full = 1'b0;
         s_next.rx_overrun = 1'b0;
      end
      // Receiver: centre sampling of each bit
      if (s_reg.tick) begin
         case (s_reg.rx_state)
            RX_IDLE: begin
               if (!rx_level) begin
                  s_next.rx_state = RX_SHIFT;
                  s_next.rx_sub = 5'h00;
                  s_next.rx_bits = nine ? 4'ha : 4'h9;
                  s_next.idle_cnt = 5'h00;
               end else if (s_reg.idle_cnt == TICKS_PER_BIT) begin
                  s_next.rx_idle_flag = 1'b1;
               end else begin
                  s_next.idle_cnt = s_reg.idle_cnt + 5'h01;
               end
            end
            RX_SHIFT: begin
               s_next.rx_idle_flag = 1'b0;
               if (s_reg.rx_sub == 5'h0f) begin
                  s_next.rx_sub = 5'h00;
               end else begin
                  s_next.rx_sub = s_reg.rx_sub + 5'h01;
               end
               if (s_reg.rx_sub == 5'h07) begin
                  s_next.rx_bits = s_reg.rx_bits - 4'h1;
                  if (s_reg.rx_bits == 4'h0) begin
                     s_next.rx_state = RX_IDLE;
                     s_next.rx_frame_err = !rx_level;
                     if (s_reg.rx_full && !rx_read) begin
                        s_next.rx_overrun = 1'b1;
                     end else begin
                        s_next.rx_full = 1'b1;
                        s_next.rx_data = nine ? s_reg.rx_shift : {1'b0, s_reg.rx_shift[8:1]};
                     end
                  end else if (s_reg.rx_bits != (nine ? 4'ha : 4'h9)) begin
                     s_next.rx_shift = {rx_level, s_reg.rx_shift[8:1]};
                  end
               end
            end
            default: s_next.rx_state = RX_IDLE;
         endcase
      end
      // Register writes on the access edge
      if (access && s_reg.pready && pwrite && mapped) begin
         case (idx)
            IDX_BAUD_HIGH: begin
               if (!alt_map) begin
                  s_next.baud_high_hold = pwdata[7:0];
               end
            end
            IDX_BAUD_LOW: begin
               if (alt_map) begin
                  s_next.alt_ctrl_one = pwdata[7:0] & 8'h83;
               end else begin
                  s_next.baud_low = pwdata[7:0];
                  s_next.baud_high = s_reg.baud_high_hold;
               end
            end
            IDX_LINE_CTRL_ONE: begin
               if (alt_map) begin
                  s_next.alt_ctrl_two = pwdata[2:0];
               end else begin
                  s_next.ctrl_one = pwdata[7:0];
               end
            end
            IDX_LINE_CTRL_TWO: begin
               s_next.ctrl_two = pwdata[7:0];
               if (pwdata[BIT_TX_ENABLE] || pwdata[BIT_RX_ENABLE]) begin
                  s_next.started = 1'b1;
               end
            end
            IDX_LINE_STAT_TWO: s_next.stat_two = pwdata[7:0] & 8'h98;
            IDX_DATA_HIGH: s_next.tx_data[8] = pwdata[BIT_TX_NINTH];
            IDX_DATA_LOW: begin
               s_next.tx_data[7:0] = pwdata[7:0];
               s_next.tx_full = 1'b1;
            end
            default: s_next.started = s_reg.started;
         endcase
      end
      // Polarity is folded in before the flop so the pin comes straight from state
      s_next.tx_pin = s_next.tx_line ^ s_next.stat_two[BIT_TX_POL];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg <= '0;
         s_reg.baud_high <= RST_BAUD_HIGH;
         s_reg.baud_high_hold <= RST_BAUD_HIGH;
         s_reg.baud_low <= RST_BAUD_LOW;
         s_reg.tx_state <= TX_IDLE;
         s_reg.rx_state <= RX_IDLE;
         s_reg.tx_line <= 1'b1;
         s_reg.tx_oe_n <= 1'b1;
         s_reg.tx_pin <= 1'b1;
      end else if (clk_en) begin
         s_reg <= s_next;
      end
   end

   always_comb begin
      prdata = s_reg.prdata;
      pready = s_reg.pready;
      pslverr = 1'b0;
      tx_out = s_reg.tx_pin;
      tx_oe_n = s_reg.tx_oe_n;
   end

   // ==========================================
   // Checks
   AST_TX_HIZ: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && !s_reg.ctrl_two[BIT_TX_ENABLE] |=> tx_oe_n)
      else $error("tx driven while disabled");
   AST_TX_IDLE_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
      s_reg.tx_state == TX_IDLE && !tx_oe_n |-> s_reg.tx_line)
      else $error("tx not idle high");
   AST_STOPPED: assert property (@(posedge pclk) disable iff (!presetn)
      !s_reg.started |-> s_reg.baud_cnt == 13'h0000 && !s_reg.tick)
      else $error("baud ran before enable");
   AST_ZERO_DIV: assert property (@(posedge pclk) disable iff (!presetn)
      eff_div == 13'h0000 |=> !s_reg.tick)
      else $error("baud ran with zero divisor");
   AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && access && s_reg.pready && pwrite && mapped && idx == IDX_BAUD_HIGH
      && !alt_map |=> $stable(s_reg.baud_high))
      else $error("high byte applied early");
   AST_RESERVED: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && !mapped |=> prdata == 32'h00000000)
      else $error("unmapped read not zero");
   AST_ALT: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && mapped && alt_map && idx == IDX_BAUD_HIGH |=> prdata == 32'h0)
      else $error("alternate map decode");
   AST_READY: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && psel && !penable |=> pready)
      else $error("no ready");
   AST_RX_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && !s_reg.ctrl_two[BIT_RX_ENABLE] && s_reg.rx_state == RX_IDLE
      |=> s_reg.rx_state == RX_IDLE)
      else $error("receiver left idle while disabled");
   AST_LOW_APPLIES: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && access && s_reg.pready && pwrite && mapped && idx == IDX_BAUD_LOW
      && !alt_map |=> s_reg.baud_high == $past(s_reg.baud_high_hold))
      else $error("held high byte not applied");
   COV_ALT: cover property (@(posedge pclk) alt_map && access && s_reg.pready);
   COV_POL: cover property (@(posedge pclk) s_reg.stat_two[BIT_TX_POL] && !tx_oe_n);
   COV_TX: cover property (@(posedge pclk) s_reg.tx_done);
   COV_RX: cover property (@(posedge pclk) s_reg.rx_full);
   COV_IR: cover property (@(posedge pclk) ir_on && s_reg.tx_state == TX_SHIFT);
endmodule : serial_port

// File: serial_port_pkg.sv
// Constants for the asynchronous serial port front end.
// Assumes an 8-bit register file behind a 32-bit APB slave, one word per register.
package serial_port_pkg;
   // ==========================================
   // Register indices (byte address is four times the index)
   localparam logic [2:0] IDX_BAUD_HIGH = 3'h0;
   localparam logic [2:0] IDX_BAUD_LOW = 3'h1;
   localparam logic [2:0] IDX_LINE_CTRL_ONE = 3'h2;
   localparam logic [2:0] IDX_LINE_CTRL_TWO = 3'h3;
   localparam logic [2:0] IDX_LINE_STAT_ONE = 3'h4;
   localparam logic [2:0] IDX_LINE_STAT_TWO = 3'h5;
   localparam logic [2:0] IDX_DATA_HIGH = 3'h6;
   localparam logic [2:0] IDX_DATA_LOW = 3'h7;
   localparam int REG_COUNT = 8;
   // ==========================================
   // Field positions
   localparam int BIT_INFRARED_ENABLE = 7;
   localparam int POS_PULSE_HI = 6;
   localparam int POS_PULSE_LO = 5;
   localparam int POS_DIV_HI = 4;
   localparam int BIT_CHAR_LENGTH = 4;
   localparam int BIT_TX_ENABLE = 3;
   localparam int BIT_RX_ENABLE = 2;
   localparam int BIT_ALT_MAP = 7;
   localparam int BIT_TX_POL = 4;
   localparam int BIT_RX_POL = 3;
   localparam int BIT_RX_NINTH = 7;
   localparam int BIT_TX_NINTH = 6;
   // ==========================================
   // Reset values
   localparam logic [7:0] RST_BAUD_HIGH = 8'h00;
   localparam logic [7:0] RST_BAUD_LOW = 8'h04;
   localparam logic [7:0] RST_ZERO = 8'h00;
   // ==========================================
   // Timing: sixteenth bit ticks per bit
   localparam logic [4:0] TICKS_PER_BIT = 5'h10;
   localparam logic [4:0] TICKS_PER_BIT_IR = 5'h10;
   // Pulse widths in 1/32 bit units for the narrow pulse field
   localparam logic [4:0] PULSE_QUARTER = 5'h08;
   localparam logic [4:0] PULSE_1_32 = 5'h01;
   localparam logic [4:0] PULSE_1_16 = 5'h02;
   localparam logic [4:0] PULSE_3_16 = 5'h06;
   typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} tx_state_t;
   typedef enum logic [1:0] {RX_IDLE, RX_SHIFT} rx_state_t;
endpackage : serial_port_pkg
